// ==== design/csm_params.svh ====
// Timing and frame constants of the controller serial master ports
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
`define CSM_CORE_PER_PS      10000
`define CSM_FLASH_MIN_PER_PS 20000
`define CSM_FLASH_MAX_PER_PS 100000
`define CSM_MGMT_MIN_PER_PS  33300
`define CSM_MGMT_MAX_PER_PS  100000
`define CSM_RB_MIN_PER_PS    33327
`define CSM_RB_MAX_PER_PS    34100
`define CSM_RB_MIN_DUTY_PCT  40
// Half period in core cycles; least period rounds up
`define CSM_FLASH_HALF ((`CSM_FLASH_MIN_PER_PS + 2 * `CSM_CORE_PER_PS - 1) \
                        / (2 * `CSM_CORE_PER_PS))
`define CSM_MGMT_HALF ((`CSM_MGMT_MIN_PER_PS + 2 * `CSM_CORE_PER_PS - 1) \
                       / (2 * `CSM_CORE_PER_PS))
`define CSM_WORD_BITS        8
`define CSM_SINGLE_CLKS      4'h7
`define CSM_QUAD_CLKS        4'h1
`define CSM_RB_BITS          16
`define CSM_SEL_IDLE         1'b1
`define CSM_SCLK_IDLE        1'b0
`endif

// ==== design/csm_pkg.sv ====
// Types of the controller serial master ports
package csm_pkg;
   typedef enum logic [3:0] {
      csm_e_idle = 4'h1,
      csm_e_low  = 4'h2,
      csm_e_high = 4'h4,
      csm_e_tail = 4'h8
   } csm_eng_state_t;
   typedef enum logic [2:0] {
      csm_l_idle  = 3'h1,
      csm_l_shift = 3'h2,
      csm_l_tail  = 3'h4
   } csm_link_state_t;
endpackage

// ==== design/csm_serial_ports.sv ====
// Flash, management and readback serial master ports
`timescale 1ns/10ps
`default_nettype none
`include "csm_params.svh"

module csm_spi_eng #(
   parameter int         LANES    = 1,
   parameter int         SIN_LANE = 0,
   parameter logic [7:0] HALF     = 8'h01
) (
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             core_ce_i,
   input  wire logic             req_i,
   input  wire logic             quad_i,
   input  wire logic             drive_i,
   input  wire logic             keep_sel_i,
   input  wire logic [7:0]       tx_i,
   output logic                  ready_o,
   output logic                  done_o,
   output logic [7:0]            rx_o,
   output logic                  sclk_o,
   output logic                  sel_n_o,
   output logic [LANES-1:0]      dout_o,
   output logic [LANES-1:0]      oe_n_o,
   input  wire logic [LANES-1:0] din_i
);
   typedef struct packed {
      csm_pkg::csm_eng_state_t st;
      logic [7:0]              div;
      logic [3:0]              clks;
      logic                    quad;
      logic                    drive;
      logic                    keep;
      logic [7:0]              tx;
      logic [7:0]              rx;
      logic [1:0]              pipe;
      logic [LANES-1:0]        s1;
      logic [LANES-1:0]        s2;
      logic                    sclk;
      logic                    sel_n;
      logic                    ready;
      logic                    done;
      logic [LANES-1:0]        dout;
      logic [LANES-1:0]        oe_n;
   } csm_eng_st_t;

   localparam csm_eng_st_t RST = '{st: csm_pkg::csm_e_idle,
      sclk: `CSM_SCLK_IDLE, sel_n: `CSM_SEL_IDLE, ready: 1'b1,
      oe_n: {LANES{1'b1}}, default: '0};

   csm_eng_st_t q;
   csm_eng_st_t d;
   logic [3:0]  in_w;

   // Lanes driven for the leading bits of the shift word
   function automatic logic [2*LANES-1:0] lanes_out(input logic [7:0] w,
         input logic qd, input logic drv);
      logic [LANES-1:0] o;
      logic [LANES-1:0] e;
      o = qd ? LANES'(w[7:4]) : LANES'(w[7]);
      e = qd ? (drv ? {LANES{1'b0}} : {LANES{1'b1}})
             : ~LANES'(1'b1);
      return {o, e};
   endfunction

   always_comb begin
      in_w = 4'(q.s2);
      d = q;
      d.done = 1'b0;
      d.s1 = din_i;
      d.s2 = q.s1;
      d.pipe = {q.pipe[0], 1'b0};
      if (q.pipe[1]) begin
         d.rx = q.quad ? {q.rx[3:0], in_w} : {q.rx[6:0], in_w[SIN_LANE]};
      end
      case (q.st)
         csm_pkg::csm_e_idle: begin
            if (req_i) begin
               d.quad = quad_i && (LANES == 4);
               d.drive = drive_i;
               d.keep = keep_sel_i;
               d.tx = tx_i;
               d.clks = (quad_i && (LANES == 4)) ? `CSM_QUAD_CLKS
                                                 : `CSM_SINGLE_CLKS;
               d.sel_n = 1'b0;
               {d.dout, d.oe_n} = lanes_out(tx_i, quad_i && (LANES == 4),
                                            drive_i);
               d.div = HALF - 8'h01;
               d.ready = 1'b0;
               d.st = csm_pkg::csm_e_low;
            end
         end
         csm_pkg::csm_e_low: begin
            if (q.div == 8'h00) begin
               d.sclk = 1'b1;
               d.div = HALF - 8'h01;
               d.st = csm_pkg::csm_e_high;
            end else begin
               d.div = q.div - 8'h01;
            end
         end
         csm_pkg::csm_e_high: begin
            if (q.div == 8'h00) begin
               d.sclk = 1'b0;
               d.pipe[0] = 1'b1;
               d.div = HALF - 8'h01;
               if (q.clks == 4'h0) begin
                  d.st = csm_pkg::csm_e_tail;
               end else begin
                  d.clks = q.clks - 4'h1;
                  d.tx = q.quad ? {q.tx[3:0], 4'h0} : {q.tx[6:0], 1'b0};
                  {d.dout, d.oe_n} = lanes_out(d.tx, q.quad, q.drive);
                  d.st = csm_pkg::csm_e_low;
               end
            end else begin
               d.div = q.div - 8'h01;
            end
         end
         csm_pkg::csm_e_tail: begin
            // Wait out the capture pipe so the last bit lands
            if (q.pipe == 2'b00) begin
               d.done = 1'b1;
               d.ready = 1'b1;
               d.sel_n = ~q.keep;
               d.oe_n = {LANES{1'b1}};
               d.st = csm_pkg::csm_e_idle;
            end
         end
         default: begin
            d = RST;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         q <= RST;
      end else if (core_ce_i) begin
         q <= d;
      end
   end

   assign ready_o = q.ready;
   assign done_o = q.done;
   assign rx_o = q.rx;
   assign sclk_o = q.sclk;
   assign sel_n_o = q.sel_n;
   assign dout_o = q.dout;
   assign oe_n_o = q.oe_n;
endmodule

module csm_rb_link #(
   parameter int BITS = `CSM_RB_BITS
) (
   input  wire logic            link_clk_i,
   input  wire logic            sys_rst_i,
   input  wire logic            req_tgl_i,
   input  wire logic [BITS-1:0] cmd_i,
   output logic                 done_tgl_o,
   output logic [BITS-1:0]      rx_o,
   output logic                 rb_clk_o,
   output logic                 rb_out_o,
   input  wire logic            rb_in_i
);
   typedef struct packed {
      logic [1:0]               rs;
      logic [1:0]               rq;
      logic                     i1;
      logic                     i2;
      logic                     ack;
      csm_pkg::csm_link_state_t st;
      logic                     clk;
      logic                     out;
      logic [7:0]               cnt;
      logic [BITS-1:0]          sh;
      logic [BITS-1:0]          x;
      logic [BITS-1:0]          rx;
      logic [1:0]               pipe;
      logic                     done_tgl;
   } csm_link_st_t;

   csm_link_st_t q;
   csm_link_st_t d;

   always_comb begin
      d = q;
      d.rs = {q.rs[0], sys_rst_i};
      d.rq = {q.rq[0], req_tgl_i};
      d.i1 = rb_in_i;
      d.i2 = q.i1;
      d.clk = ~q.clk;
      d.pipe = {q.pipe[0], 1'b0};
      if (q.pipe[1]) begin
         d.x = {q.x[BITS-2:0], q.i2};
      end
      case (q.st)
         csm_pkg::csm_link_state_t'(csm_pkg::csm_l_idle): begin
            if (q.clk && (q.rq[1] != q.ack)) begin
               d.ack = q.rq[1];
               d.out = cmd_i[BITS-1];
               d.sh = {cmd_i[BITS-2:0], 1'b0};
               d.cnt = 8'(BITS);
               d.st = csm_pkg::csm_l_shift;
            end
         end
         csm_pkg::csm_l_shift: begin
            if (!q.clk) begin
               d.pipe[0] = 1'b1;
               d.cnt = q.cnt - 8'h01;
            end else if (q.cnt == 8'h00) begin
               d.out = 1'b0;
               d.st = csm_pkg::csm_l_tail;
            end else begin
               d.out = q.sh[BITS-1];
               d.sh = {q.sh[BITS-2:0], 1'b0};
            end
         end
         csm_pkg::csm_l_tail: begin
            if (q.pipe == 2'b00) begin
               d.rx = q.x;
               d.done_tgl = ~q.done_tgl;
               d.st = csm_pkg::csm_l_idle;
            end
         end
         default: begin
            d.st = csm_pkg::csm_l_idle;
         end
      endcase
      // Reset arrives from the core domain through two flops
      if (q.rs[1]) begin
         d.ack = q.rq[1];
         d.st = csm_pkg::csm_l_idle;
         d.clk = 1'b0;
         d.out = 1'b0;
         d.cnt = 8'h00;
         d.sh = '0;
         d.x = '0;
         d.rx = '0;
         d.pipe = 2'b00;
         d.done_tgl = 1'b0;
      end
   end

   always_ff @(posedge link_clk_i) begin
      q <= d;
   end

   assign done_tgl_o = q.done_tgl;
   assign rx_o = q.rx;
   assign rb_clk_o = q.clk;
   assign rb_out_o = q.out;
endmodule

module csm_serial_ports (
   input  wire logic                   core_clk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   core_ce_i,
   input  wire logic                   link_clk_i,
   input  wire logic                   flash_req_i,
   input  wire logic                   flash_quad_i,
   input  wire logic                   flash_drive_i,
   input  wire logic                   flash_keep_i,
   input  wire logic [7:0]             flash_tx_i,
   output logic                        flash_ready_o,
   output logic                        flash_done_o,
   output logic [7:0]                  flash_rx_o,
   output logic                        flash_serial_clock_o,
   output logic                        flash_select_n_o,
   output logic [3:0]                  flash_serial_io_o,
   output logic [3:0]                  flash_serial_io_oe_n_o,
   input  wire logic [3:0]             flash_serial_io_i,
   input  wire logic                   mgmt_req_i,
   input  wire logic                   mgmt_keep_i,
   input  wire logic [7:0]             mgmt_tx_i,
   output logic                        mgmt_ready_o,
   output logic                        mgmt_done_o,
   output logic [7:0]                  mgmt_rx_o,
   output logic                        mgmt_serial_clock_o,
   output logic                        mgmt_select0_n_o,
   output logic                        mgmt_serial_out_o,
   input  wire logic                   mgmt_serial_in_i,
   input  wire logic                   rb_req_i,
   input  wire logic [`CSM_RB_BITS-1:0] rb_cmd_i,
   output logic                        rb_ready_o,
   output logic                        rb_done_o,
   output logic [`CSM_RB_BITS-1:0]     rb_data_o,
   output logic                        readback_link_clock_o,
   output logic                        readback_link_out_o,
   input  wire logic                   readback_link_in_i
);
   typedef struct packed {
      logic                    tgl;
      logic [`CSM_RB_BITS-1:0] cmd;
      logic                    idle;
      logic [1:0]              dn;
      logic                    seen;
      logic [`CSM_RB_BITS-1:0] data;
      logic                    done;
   } csm_core_st_t;

   csm_core_st_t            q;
   csm_core_st_t            d;
   logic                    link_done_tgl;
   logic [`CSM_RB_BITS-1:0] link_rx;

   // Quad flash engine, input on lane 1
   csm_spi_eng #(
      .LANES    (4),
      .SIN_LANE (1),
      .HALF     (8'(`CSM_FLASH_HALF))
   ) u_flash (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .core_ce_i  (core_ce_i),
      .req_i      (flash_req_i),
      .quad_i     (flash_quad_i),
      .drive_i    (flash_drive_i),
      .keep_sel_i (flash_keep_i),
      .tx_i       (flash_tx_i),
      .ready_o    (flash_ready_o),
      .done_o     (flash_done_o),
      .rx_o       (flash_rx_o),
      .sclk_o     (flash_serial_clock_o),
      .sel_n_o    (flash_select_n_o),
      .dout_o     (flash_serial_io_o),
      .oe_n_o     (flash_serial_io_oe_n_o),
      .din_i      (flash_serial_io_i)
   );

   csm_spi_eng #(
      .LANES    (1),
      .SIN_LANE (0),
      .HALF     (8'(`CSM_MGMT_HALF))
   ) u_mgmt (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .core_ce_i  (core_ce_i),
      .req_i      (mgmt_req_i),
      .quad_i     (1'b0),
      .drive_i    (1'b1),
      .keep_sel_i (mgmt_keep_i),
      .tx_i       (mgmt_tx_i),
      .ready_o    (mgmt_ready_o),
      .done_o     (mgmt_done_o),
      .rx_o       (mgmt_rx_o),
      .sclk_o     (mgmt_serial_clock_o),
      .sel_n_o    (mgmt_select0_n_o),
      .dout_o     (mgmt_serial_out_o),
      .oe_n_o     (),
      .din_i      (mgmt_serial_in_i)
   );

   // Link clock halved; needs a 58.65 to 60.01 MHz link_clk_i
   csm_rb_link #(
      .BITS (`CSM_RB_BITS)
   ) u_link (
      .link_clk_i (link_clk_i),
      .sys_rst_i  (sys_rst_i),
      .req_tgl_i  (q.tgl),
      .cmd_i      (q.cmd),
      .done_tgl_o (link_done_tgl),
      .rx_o       (link_rx),
      .rb_clk_o   (readback_link_clock_o),
      .rb_out_o   (readback_link_out_o),
      .rb_in_i    (readback_link_in_i)
   );

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.dn = {q.dn[0], link_done_tgl};
      // Command word stays put until the link hands back, so it crosses safely
      if (q.idle && rb_req_i) begin
         d.cmd = rb_cmd_i;
         d.tgl = ~q.tgl;
         d.idle = 1'b0;
      end
      if (q.dn[1] != q.seen) begin
         d.seen = q.dn[1];
         d.data = link_rx;
         d.done = 1'b1;
         d.idle = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         q <= '{idle: 1'b1, default: '0};
      end else if (core_ce_i) begin
         q <= d;
      end
   end

   assign rb_ready_o = q.idle;
   assign rb_done_o = q.done;
   assign rb_data_o = q.data;
endmodule

`default_nettype wire

// ==== sim/csm_serial_ports_chk.sv ====
// Port checker of the controller serial master ports
`timescale 1ns/10ps
`default_nettype none
module csm_serial_ports_chk (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       core_ce_i,
   input  wire logic       link_clk_i,
   input  wire logic       flash_req_i,
   input  wire logic       flash_quad_i,
   input  wire logic       flash_ready_o,
   input  wire logic       flash_done_o,
   input  wire logic       flash_serial_clock_o,
   input  wire logic       flash_select_n_o,
   input  wire logic [3:0] flash_serial_io_o,
   input  wire logic       mgmt_ready_o,
   input  wire logic       mgmt_serial_clock_o,
   input  wire logic       mgmt_select0_n_o,
   input  wire logic       mgmt_serial_out_o,
   input  wire logic       readback_link_clock_o,
   input  wire logic       readback_link_out_o
);
   a_flash_idle_low: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) flash_ready_o |-> !flash_serial_clock_o)
      else $error("flash clock not idle low");
   a_single_word_len: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) flash_ready_o && flash_req_i && core_ce_i
      && !flash_quad_i |=> !flash_ready_o ##[15:19] flash_done_o)
      else $error("flash single word length wrong");
   a_flash_io_launch: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) $changed(flash_serial_io_o) && !flash_ready_o
      |-> $fell(flash_serial_clock_o) || $past(flash_ready_o))
      else $error("flash data moved off a falling edge");
   a_flash_half_per: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) $rose(flash_serial_clock_o)
      |=> !flash_serial_clock_o)
      else $error("flash clock high time wrong");
   a_flash_sel_lead: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) flash_serial_clock_o
      |-> !flash_select_n_o && !$past(flash_select_n_o))
      else $error("flash select not ahead of clock");
   a_mgmt_idle_low: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) mgmt_ready_o |-> !mgmt_serial_clock_o)
      else $error("mgmt clock not idle low");
   a_mgmt_half_per: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) $rose(mgmt_serial_clock_o)
      |=> mgmt_serial_clock_o ##1 !mgmt_serial_clock_o)
      else $error("mgmt clock high time wrong");
   a_mgmt_out_launch: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) $changed(mgmt_serial_out_o) && !mgmt_ready_o
      |-> $fell(mgmt_serial_clock_o) || $past(mgmt_ready_o))
      else $error("mgmt data moved off a falling edge");
   a_mgmt_sel_hold: assert property (@(posedge core_clk_i)
      disable iff (sys_rst_i) mgmt_serial_clock_o |-> !mgmt_select0_n_o)
      else $error("mgmt clock while deselected");
   a_rb_free_run: assert property (@(posedge link_clk_i)
      disable iff (sys_rst_i) !sys_rst_i [*8]
      |-> readback_link_clock_o != $past(readback_link_clock_o))
      else $error("readback clock stopped");
   a_rb_out_fall: assert property (@(posedge link_clk_i)
      disable iff (sys_rst_i) $changed(readback_link_out_o)
      |-> $fell(readback_link_clock_o))
      else $error("readback out moved off a falling edge");
endmodule
`default_nettype wire

// ==== sim/csm_partner.sv ====
// Flash, management chip and companion readback models
`timescale 1ns/10ps
`default_nettype none
module csm_partner (
   input  wire logic       quad_i,
   input  wire logic [7:0] f_reply_i,
   input  wire logic [7:0] m_reply_i,
   input  wire logic       f_clk_i,
   input  wire logic       f_sel_n_i,
   input  wire logic [3:0] f_io_i,
   input  wire logic [3:0] f_oe_n_i,
   output logic      [3:0] f_io_o,
   output logic      [7:0] f_got_o,
   input  wire logic       m_clk_i,
   input  wire logic       m_sel_n_i,
   input  wire logic       m_din_i,
   output logic            m_dout_o,
   output logic      [7:0] m_got_o,
   input  wire logic       r_clk_i,
   input  wire logic       r_out_i,
   output logic            r_in_o
);
   logic [7:0] f_sh = 8'hA5;
   logic [7:0] m_sh = 8'h5A;
   logic       r_last = 1'b0;
   logic [3:0] f_pv;
   assign f_pv = quad_i ? f_sh[7:4] : {4{f_sh[7]}};
   // Lane level from whoever drives it
   assign f_io_o = (f_io_i & ~f_oe_n_i) | (f_pv & f_oe_n_i);
   assign m_dout_o = m_sh[7];
   initial r_in_o = 1'b1;
   always @(negedge f_sel_n_i) f_sh = f_reply_i;
   always @(negedge m_sel_n_i) m_sh = m_reply_i;
   // next bit only at the falling edge, held a full period
   always @(negedge f_clk_i) if (!f_sel_n_i)
      f_sh = quad_i ? {f_sh[3:0], f_sh[7:4]} : {f_sh[6:0], f_sh[7]};
   always @(negedge m_clk_i) if (!m_sel_n_i) m_sh = {m_sh[6:0], m_sh[7]};
   // Released lines show the inverse, so stale data cannot pass
   always @(posedge f_sel_n_i) f_sh = ~f_sh;
   always @(posedge m_sel_n_i) m_sh = ~m_sh;
   always @(posedge f_clk_i)
      f_got_o = quad_i ? {f_got_o[3:0], f_io_o} : {f_got_o[6:0], f_io_o[0]};
   always @(posedge m_clk_i) m_got_o = {m_got_o[6:0], m_din_i};
   // companion echoes the inverse of the last out bit
   always @(posedge r_clk_i) r_last <= r_out_i;
   always @(negedge r_clk_i) r_in_o <= ~r_last;
endmodule
`default_nettype wire

// ==== sim/csm_serial_ports_tb_top.sv ====
// Testbench of the controller serial master ports
`timescale 1ns/10ps
`default_nettype none
module csm_serial_ports_tb_top;
   logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, core_ce_i = 1'b1;
   logic        link_clk_i = 1'b0, flash_req_i = 1'b0, flash_quad_i = 1'b0;
   logic        flash_drive_i = 1'b0, flash_keep_i = 1'b0, mgmt_req_i = 1'b0;
   logic        mgmt_keep_i = 1'b0, rb_req_i = 1'b0;
   logic [7:0]  flash_tx_i = 8'h00, mgmt_tx_i = 8'h00;
   logic [7:0]  f_reply = 8'h00, m_reply = 8'h00, f_got, m_got, flash_rx_o;
   logic [7:0]  mgmt_rx_o;
   logic [15:0] rb_cmd_i = 16'h0000, rb_data_o;
   logic [3:0]  flash_serial_io_o, flash_serial_io_oe_n_o, flash_serial_io_i;
   logic        flash_ready_o, flash_done_o, flash_serial_clock_o;
   logic        flash_select_n_o, mgmt_ready_o, mgmt_done_o, mgmt_select0_n_o;
   logic        mgmt_serial_clock_o, mgmt_serial_out_o, mgmt_serial_in_i;
   logic        rb_ready_o, rb_done_o, readback_link_clock_o;
   logic        readback_link_out_o, readback_link_in_i;
   int          n_mismatch = 0, comparisons = 0;
   realtime     f_t = 0, m_t = 0, r_t = 0, f_min = 1e6, m_min = 1e6;
   realtime     r_hi = 0, r_lo = 0;

   initial forever #5 core_clk_i = ~core_clk_i;
   // Offset of 1 ns; link edges still meet core edges once every 80 ns
   initial begin
      #1;
      forever #16 link_clk_i = ~link_clk_i;
   end

   csm_serial_ports dut_u (.core_clk_i, .sys_rst_i, .core_ce_i, .link_clk_i,
      .flash_req_i, .flash_quad_i, .flash_drive_i, .flash_keep_i, .flash_tx_i,
      .flash_ready_o, .flash_done_o, .flash_rx_o, .flash_serial_clock_o,
      .flash_select_n_o, .flash_serial_io_o, .flash_serial_io_oe_n_o,
      .flash_serial_io_i, .mgmt_req_i, .mgmt_keep_i, .mgmt_tx_i, .mgmt_ready_o,
      .mgmt_done_o, .mgmt_rx_o, .mgmt_serial_clock_o, .mgmt_select0_n_o,
      .mgmt_serial_out_o, .mgmt_serial_in_i, .rb_req_i, .rb_cmd_i, .rb_ready_o,
      .rb_done_o, .rb_data_o, .readback_link_clock_o, .readback_link_out_o,
      .readback_link_in_i);

   csm_partner partner_u (.quad_i(flash_quad_i), .f_reply_i(f_reply),
      .m_reply_i(m_reply), .f_clk_i(flash_serial_clock_o),
      .f_sel_n_i(flash_select_n_o), .f_io_i(flash_serial_io_o),
      .f_oe_n_i(flash_serial_io_oe_n_o), .f_io_o(flash_serial_io_i),
      .f_got_o(f_got), .m_clk_i(mgmt_serial_clock_o),
      .m_sel_n_i(mgmt_select0_n_o), .m_din_i(mgmt_serial_out_o),
      .m_dout_o(mgmt_serial_in_i), .m_got_o(m_got),
      .r_clk_i(readback_link_clock_o), .r_out_i(readback_link_out_o),
      .r_in_o(readback_link_in_i));

   always @(posedge flash_serial_clock_o) begin
      if (f_t > 0 && $realtime - f_t < f_min) f_min = $realtime - f_t;
      f_t = $realtime;
   end
   always @(posedge mgmt_serial_clock_o) begin
      if (m_t > 0 && $realtime - m_t < m_min) m_min = $realtime - m_t;
      m_t = $realtime;
   end
   always @(readback_link_clock_o) begin
      if (readback_link_clock_o) r_lo = $realtime - r_t;
      else r_hi = $realtime - r_t;
      r_t = $realtime;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wait_done(ref logic done, input int lim);
      int n = 0;
      while (done !== 1'b1 && n < lim) begin
         @(negedge core_clk_i);
         n++;
      end
      check("done pulse", {15'h0, done}, 16'h0001);
   endtask

   task automatic flash_word(input logic q, d, k, input logic [7:0] tx, rep);
      @(negedge core_clk_i);
      flash_quad_i = q;
      flash_drive_i = d;
      flash_keep_i = k;
      flash_tx_i = tx;
      f_reply = rep;
      flash_req_i = 1'b1;
      @(negedge core_clk_i);
      flash_req_i = 1'b0;
      wait_done(flash_done_o, 100);
      check("flash select", {15'h0, flash_select_n_o}, {15'h0, ~k});
   endtask

   task automatic mgmt_word(input logic k, input logic [7:0] tx, rep,
         input int frz);
      @(negedge core_clk_i);
      mgmt_keep_i = k;
      mgmt_tx_i = tx;
      m_reply = rep;
      mgmt_req_i = 1'b1;
      @(negedge core_clk_i);
      mgmt_req_i = 1'b0;
      // Freeze while the clock is low, then the word must still finish
      if (frz > 0) begin
         core_ce_i = 1'b0;
         repeat (frz) @(negedge core_clk_i);
         check("mgmt frozen", {15'h0, mgmt_serial_clock_o}, 16'h0);
         core_ce_i = 1'b1;
      end
      wait_done(mgmt_done_o, 100);
      check("mgmt rx", {8'h0, mgmt_rx_o}, {8'h0, rep});
      check("mgmt sent", {8'h0, m_got}, {8'h0, tx});
      check("mgmt select", {15'h0, mgmt_select0_n_o}, {15'h0, ~k});
   endtask

   task automatic t_idle;
      check("flash select", {15'h0, flash_select_n_o}, 16'h0001);
      check("flash clock", {15'h0, flash_serial_clock_o}, 16'h0);
      check("flash oe", {12'h0, flash_serial_io_oe_n_o}, 16'h000F);
      check("mgmt clock", {15'h0, mgmt_serial_clock_o}, 16'h0);
      $display("Test idle done");
   endtask

   task automatic t_flash;
      flash_word(1'b0, 1'b1, 1'b0, 8'hC3, 8'h96);
      check("flash rx", {8'h0, flash_rx_o}, 16'h0096);
      check("flash sent", {8'h0, f_got}, 16'h00C3);
      // Select stays low, so this reply is what the next word reads back
      flash_word(1'b1, 1'b1, 1'b1, 8'h5E, 8'hB7);
      check("quad sent", {8'h0, f_got}, 16'h005E);
      flash_word(1'b1, 1'b0, 1'b0, 8'h00, 8'hB7);
      check("quad rx", {8'h0, flash_rx_o}, 16'h00B7);
      $display("Test flash done");
   endtask

   task automatic t_mgmt;
      mgmt_word(1'b0, 8'hA1, 8'h3C, 0);
      mgmt_word(1'b0, 8'h6D, 8'hC5, 6);
      mgmt_word(1'b1, 8'h80, 8'h01, 0); // last bit
      $display("Test mgmt done");
   endtask

   task automatic t_readback(input logic [15:0] cmd);
      @(negedge core_clk_i);
      rb_cmd_i = cmd;
      rb_req_i = 1'b1;
      @(negedge core_clk_i);
      rb_req_i = 1'b0;
      check("readback ready", {15'h0, rb_ready_o}, 16'h0000);
      wait_done(rb_done_o, 400);
      check("readback rx", rb_data_o, {1'b1, ~cmd[15:1]});
      $display("Test readback done");
   endtask

   task automatic t_clocks;
      check("flash period", 16'(f_min >= 20.0 && f_min <= 100.0), 1);
      check("mgmt period", 16'(m_min >= 33.3 && m_min <= 100.0), 1);
      check("rb high", 16'(r_hi * 100 >= (r_hi + r_lo) * 40), 1);
      check("rb low", 16'(r_lo * 100 >= (r_hi + r_lo) * 40), 1);
      $display("Test clocks done");
   endtask

   initial begin
      #100000;
      n_mismatch++;
      give_verdict;
   end

   initial begin
      repeat (12) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      repeat (20) @(negedge core_clk_i);
      t_idle;
      t_flash;
      t_mgmt;
      t_readback(16'hB38D); // frame
      t_readback(16'h0001); // frame
      t_clocks;
      give_verdict;
   end
endmodule

bind csm_serial_ports csm_serial_ports_chk chk_u (.core_clk_i, .sys_rst_i,
   .core_ce_i, .link_clk_i, .flash_req_i, .flash_quad_i, .flash_ready_o,
   .flash_done_o, .flash_serial_clock_o, .flash_select_n_o,
   .flash_serial_io_o, .mgmt_ready_o, .mgmt_serial_clock_o,
   .mgmt_select0_n_o, .mgmt_serial_out_o, .readback_link_clock_o,
   .readback_link_out_o);
`default_nettype wire
